// ---- mac_irq_pkg.sv ----
// Package: register map, field positions, reset values and sizes of the interrupt flag block
package mac_irq_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LEN_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FEAT = 8'h10;
    localparam logic [7:0] OFF_EXTC = 8'h14;

    // Control register fields
    localparam int CTRL_IEN = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_SRST = 2;
    localparam int CTRL_TX_IRQ_FLAG = 3;
    localparam int CTRL_SUM = 4;

    // Test and features control fields
    localparam int FEAT_APAD = 11;
    localparam int FEAT_UCMD = 7;
    localparam int FEAT_UFLAG = 6;
    localparam int FEAT_RXCC = 5;
    localparam int FEAT_RXCCM = 4;
    localparam int FEAT_TXS = 3;
    localparam int FEAT_TXSM = 2;

    // Extended control fields
    localparam int EXTC_TOKD = 15;
    localparam int EXTC_LTEN = 14;

    // Flag slots inside the flag bank
    localparam int NFLAG = 4;
    localparam int FL_USER = 0;
    localparam int FL_RXCC = 1;
    localparam int FL_TXS = 2;
    localparam int FL_TX_IRQ_FLAG = 3;

    // Reset values
    localparam logic MASK_RST = 1'b1;
    localparam logic CTL_RST = 1'b0;
    localparam logic [NFLAG-1:0] FLAG_RST = 4'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Shortest frame that needs no padding, in bytes
    localparam logic [15:0] MIN_FRAME = 16'h0040;

endpackage : mac_irq_pkg

// ---- mac_irq_if.sv ----
// Interfaces: flag bank and transmit pad decision links
interface flag_if;
    import mac_irq_pkg::*;
    logic [NFLAG-1:0] set;
    logic [NFLAG-1:0] w1c;
    logic kill;
    logic [NFLAG-1:0] q;
    modport bank (input set, input w1c, input kill, output q);
    modport ctl (output set, output w1c, output kill, input q);
endinterface : flag_if

interface pad_if;
    import mac_irq_pkg::*;
    logic go;
    logic [LEN_W-1:0] len;
    logic desc_crc;
    logic dis_crc;
    logic auto_pad;
    logic done;
    logic pad;
    logic crc;
    modport dec (input go, input len, input desc_crc, input dis_crc, input auto_pad,
                 output done, output pad, output crc);
    modport ctl (output go, output len, output desc_crc, output dis_crc, output auto_pad,
                 input done, input pad, input crc);
endinterface : pad_if

// ---- mac_flag_bank.sv ----
// Sticky interrupt-cause flags: set by hardware, cleared by writing one
module mac_flag_bank
    import mac_irq_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Flag link
    flag_if.bank fl
);

    typedef struct packed {
        logic [NFLAG-1:0] flag;
    } bank_s;

    bank_s q_q;
    bank_s d_d;

    always_comb begin
        d_d = q_q;
        for (int i = 0; i < NFLAG; i++) begin
            // A set in a write-one-clear cycle survives; kill clears the flag even in a set cycle
            if (fl.kill) begin
                d_d.flag[i] = 1'b0;
            end else begin
                d_d.flag[i] = fl.set[i] | (q_q.flag[i] & ~fl.w1c[i]);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            q_q.flag <= FLAG_RST;
        end else begin
            q_q <= d_d;
        end
    end

    assign fl.q = q_q.flag;

endmodule : mac_flag_bank

// ---- mac_pad_decide.sv ----
// Per-frame decision on padding and checksum append
module mac_pad_decide
    import mac_irq_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Decision link
    pad_if.dec pd
);

    typedef struct packed {
        logic done;
        logic pad;
        logic crc;
    } dec_s;

    dec_s q_q;
    dec_s d_d;
    logic short_frame;

    always_comb begin
        short_frame = pd.len < MIN_FRAME;
        d_d = q_q;
        d_d.done = pd.go;
        if (pd.go) begin
            // Descriptor request beats the global disable
            d_d.crc = pd.desc_crc | ~pd.dis_crc;
            d_d.pad = 1'b0;
            if (pd.auto_pad && short_frame) begin
                d_d.pad = 1'b1;
                d_d.crc = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            q_q <= '0;
        end else begin
            q_q <= d_d;
        end
    end

    assign pd.done = q_q.done;
    assign pd.pad = q_q.pad;
    assign pd.crc = q_q.crc;

endmodule : mac_pad_decide

// ---- mac_interrupt_flag_control.sv ----
// Top: interrupt-cause flags, masks, user interrupt and pad control behind a register port
module mac_interrupt_flag_control
    import mac_irq_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [mac_irq_pkg::ADDR_W-1:0] addr_i,
    input wire logic [mac_irq_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [mac_irq_pkg::DATA_W-1:0] rdata_o,
    // Network events
    input wire logic tx_begin_i,
    input wire logic rx_coll_wrap_i,
    input wire logic tx_end_i,
    input wire logic tx_err_i,
    input wire logic desc_last_tx_irq_i,
    // Transmit frame checksum and pad request
    input wire logic tx_frame_valid_i,
    input wire logic [mac_irq_pkg::LEN_W-1:0] tx_frame_len_i,
    input wire logic descriptor_add_checksum_i,
    input wire logic disable_tx_checksum_i,
    output logic tx_decision_valid_o,
    output logic tx_pad_o,
    output logic tx_append_checksum_o,
    // Interrupt and status
    output logic irq_output_pin_o,
    output logic stop_pulse_o,
    output logic soft_reset_pulse_o
);

    typedef struct packed {
        logic global_irq_enable;
        logic auto_pad_transmit;
        logic user_irq_command;
        logic ucmd_prev;
        logic rx_collision_overflow_mask;
        logic tx_start_mask;
        logic tx_ok_irq_disable;
        logic last_tx_irq_enable;
        logic summary_irq_bit;
        logic irq;
        logic stop_p;
        logic srst_p;
        logic [DATA_W-1:0] rdata;
    } ctl_s;

    ctl_s q_q;
    ctl_s d_d;

    flag_if fl ();
    pad_if pd ();

    logic hit_ctrl;
    logic hit_feat;
    logic hit_extc;
    logic wr_ctrl;
    logic wr_feat;
    logic wr_extc;
    logic do_stop;
    logic do_srst;
    logic tx_irq_flag_set;
    logic summary;
    logic [NFLAG-1:0] fset;
    logic [NFLAG-1:0] fclr;
    logic [DATA_W-1:0] rd_word;

    mac_flag_bank u_flags (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .fl(fl.bank)
    );

    mac_pad_decide u_pad (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .pd(pd.dec)
    );

    // Decode
    always_comb begin
        hit_ctrl = addr_i == OFF_CTRL;
        hit_feat = addr_i == OFF_FEAT;
        hit_extc = addr_i == OFF_EXTC;
        wr_ctrl = wr_i & hit_ctrl;
        wr_feat = wr_i & hit_feat;
        wr_extc = wr_i & hit_extc;
        do_stop = wr_ctrl & wdata_i[CTRL_STOP];
        do_srst = wr_ctrl & wdata_i[CTRL_SRST];
    end

    // Transmit completion interrupt qualification
    always_comb begin
        tx_irq_flag_set = 1'b0;
        if (tx_end_i) begin
            if (q_q.last_tx_irq_enable) begin
                tx_irq_flag_set = desc_last_tx_irq_i | tx_err_i;
            end else if (q_q.tx_ok_irq_disable) begin
                tx_irq_flag_set = tx_err_i;
            end else begin
                tx_irq_flag_set = 1'b1;
            end
        end
    end

    // Flag set and clear sources
    always_comb begin
        fset = '0;
        fclr = '0;
        fset[FL_USER] = q_q.user_irq_command & ~q_q.ucmd_prev;
        fset[FL_RXCC] = rx_coll_wrap_i;
        fset[FL_TXS] = tx_begin_i;
        fset[FL_TX_IRQ_FLAG] = tx_irq_flag_set;
        // Ones clear, zeros leave alone
        fclr[FL_USER] = wr_feat & wdata_i[FEAT_UFLAG];
        fclr[FL_RXCC] = wr_feat & wdata_i[FEAT_RXCC];
        fclr[FL_TXS] = wr_feat & wdata_i[FEAT_TXS];
        fclr[FL_TX_IRQ_FLAG] = wr_ctrl & wdata_i[CTRL_TX_IRQ_FLAG];
    end

    assign fl.set = fset;
    assign fl.w1c = fclr;
    assign fl.kill = do_stop | do_srst;

    // Pad decision link
    assign pd.go = tx_frame_valid_i;
    assign pd.len = tx_frame_len_i;
    assign pd.desc_crc = descriptor_add_checksum_i;
    assign pd.dis_crc = disable_tx_checksum_i;
    assign pd.auto_pad = q_q.auto_pad_transmit;

    // Summary of unmasked causes
    always_comb begin
        summary = fl.q[FL_USER];
        summary = summary | (fl.q[FL_RXCC] & ~q_q.rx_collision_overflow_mask);
        summary = summary | (fl.q[FL_TXS] & ~q_q.tx_start_mask);
        summary = summary | fl.q[FL_TX_IRQ_FLAG];
    end

    // Read word assembly; reserved bits read zero
    always_comb begin
        rd_word = '0;
        case (addr_i)
            OFF_CTRL: begin
                rd_word[CTRL_IEN] = q_q.global_irq_enable;
                rd_word[CTRL_TX_IRQ_FLAG] = fl.q[FL_TX_IRQ_FLAG];
                rd_word[CTRL_SUM] = q_q.summary_irq_bit;
            end
            OFF_FEAT: begin
                rd_word[FEAT_APAD] = q_q.auto_pad_transmit;
                rd_word[FEAT_UCMD] = q_q.user_irq_command;
                rd_word[FEAT_UFLAG] = fl.q[FL_USER];
                rd_word[FEAT_RXCC] = fl.q[FL_RXCC];
                rd_word[FEAT_RXCCM] = q_q.rx_collision_overflow_mask;
                rd_word[FEAT_TXS] = fl.q[FL_TXS];
                rd_word[FEAT_TXSM] = q_q.tx_start_mask;
            end
            OFF_EXTC: begin
                rd_word[EXTC_TOKD] = q_q.tx_ok_irq_disable;
                rd_word[EXTC_LTEN] = q_q.last_tx_irq_enable;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Next state
    always_comb begin
        d_d = q_q;
        d_d.ucmd_prev = q_q.user_irq_command;
        d_d.stop_p = do_stop;
        d_d.srst_p = do_srst;
        d_d.rdata = rd_i ? rd_word : RDATA_RST;
        if (wr_ctrl) begin
            d_d.global_irq_enable = wdata_i[CTRL_IEN];
        end
        if (wr_feat) begin
            // Reserved bits written are dropped
            d_d.auto_pad_transmit = wdata_i[FEAT_APAD];
            d_d.user_irq_command = wdata_i[FEAT_UCMD];
            d_d.rx_collision_overflow_mask = wdata_i[FEAT_RXCCM];
            d_d.tx_start_mask = wdata_i[FEAT_TXSM];
            if (wdata_i[FEAT_UFLAG]) begin
                d_d.user_irq_command = 1'b0;
            end
        end
        if (wr_extc) begin
            d_d.tx_ok_irq_disable = wdata_i[EXTC_TOKD];
            d_d.last_tx_irq_enable = wdata_i[EXTC_LTEN];
        end
        if (do_stop) begin
            // Stop leaves masks and settings alone
            d_d.user_irq_command = 1'b0;
        end
        if (do_srst) begin
            d_d.global_irq_enable = CTL_RST;
            d_d.auto_pad_transmit = CTL_RST;
            d_d.user_irq_command = CTL_RST;
            d_d.rx_collision_overflow_mask = MASK_RST;
            d_d.tx_start_mask = MASK_RST;
            d_d.tx_ok_irq_disable = CTL_RST;
            d_d.last_tx_irq_enable = CTL_RST;
        end
        d_d.summary_irq_bit = summary;
        d_d.irq = q_q.global_irq_enable & summary;
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            q_q.global_irq_enable <= CTL_RST;
            q_q.auto_pad_transmit <= CTL_RST;
            q_q.user_irq_command <= CTL_RST;
            q_q.ucmd_prev <= CTL_RST;
            q_q.rx_collision_overflow_mask <= MASK_RST;
            q_q.tx_start_mask <= MASK_RST;
            q_q.tx_ok_irq_disable <= CTL_RST;
            q_q.last_tx_irq_enable <= CTL_RST;
            q_q.summary_irq_bit <= CTL_RST;
            q_q.irq <= CTL_RST;
            q_q.stop_p <= CTL_RST;
            q_q.srst_p <= CTL_RST;
            q_q.rdata <= RDATA_RST;
        end else begin
            q_q <= d_d;
        end
    end

    // Outputs
    assign rdata_o = q_q.rdata;
    assign irq_output_pin_o = q_q.irq;
    assign stop_pulse_o = q_q.stop_p;
    assign soft_reset_pulse_o = q_q.srst_p;
    assign tx_decision_valid_o = pd.done;
    assign tx_pad_o = pd.pad;
    assign tx_append_checksum_o = pd.crc;

endmodule : mac_interrupt_flag_control

// ---- mac_irq_props.sv ----
// Checker: port-level properties of the interrupt flag block
module mac_irq_props
    import mac_irq_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [mac_irq_pkg::ADDR_W-1:0] addr_i,
    input wire logic [mac_irq_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [mac_irq_pkg::DATA_W-1:0] rdata_o,
    // Pad decision
    input wire logic tx_frame_valid_i,
    input wire logic [mac_irq_pkg::LEN_W-1:0] tx_frame_len_i,
    input wire logic descriptor_add_checksum_i,
    input wire logic disable_tx_checksum_i,
    input wire logic tx_decision_valid_o,
    input wire logic tx_pad_o,
    input wire logic tx_append_checksum_o,
    // Interrupt and status
    input wire logic irq_output_pin_o,
    input wire logic stop_pulse_o,
    input wire logic soft_reset_pulse_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_ctl(int b);
        wr_i && addr_i == OFF_CTRL && wdata_i[b];
    endsequence
    sequence s_rd(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    property p_dec;
        tx_frame_valid_i |=> tx_decision_valid_o;
    endproperty
    a_dec: assert property (p_dec) else $error("decision strobe missing");
    property p_long;
        tx_frame_valid_i && tx_frame_len_i >= MIN_FRAME |=> !tx_pad_o;
    endproperty
    a_long: assert property (p_long) else $error("long frame padded");
    property p_crc;
        tx_frame_valid_i && (descriptor_add_checksum_i || !disable_tx_checksum_i)
            |=> tx_append_checksum_o;
    endproperty
    a_crc: assert property (p_crc) else $error("checksum dropped");
    property p_stop;
        s_ctl(CTRL_STOP) |=> stop_pulse_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop pulse missing");
    property p_quiet;
        s_ctl(CTRL_STOP) |-> ##2 !irq_output_pin_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq survives stop");
    property p_srst;
        s_ctl(CTRL_SRST) |=> soft_reset_pulse_o ##1 !irq_output_pin_o;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not applied");
    property p_ien;
        wr_i && addr_i == OFF_CTRL && !wdata_i[CTRL_IEN] |-> ##2 !irq_output_pin_o;
    endproperty
    a_ien: assert property (p_ien) else $error("irq while disabled");
    property p_mask;
        // No write may slip in between, or the masks may legally have been cleared
        s_ctl(CTRL_SRST) ##1 !wr_i ##1 s_rd(OFF_FEAT)
            |=> rdata_o[FEAT_TXSM] && rdata_o[FEAT_RXCCM];
    endproperty
    a_mask: assert property (p_mask) else $error("masks not set by reset");
    property p_resv;
        s_rd(OFF_EXTC) |=> rdata_o[31:16] == 16'h0000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits nonzero");
endmodule : mac_irq_props

bind mac_interrupt_flag_control mac_irq_props u_props (.clock_i, .nrst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .tx_frame_valid_i, .tx_frame_len_i, .descriptor_add_checksum_i,
    .disable_tx_checksum_i, .tx_decision_valid_o, .tx_pad_o, .tx_append_checksum_o,
    .irq_output_pin_o, .stop_pulse_o, .soft_reset_pulse_o);

// ---- tb_mac_interrupt_flag_control.sv ----
// Testbench: register, event and pad decision checks of the interrupt flag block
module tb_mac_interrupt_flag_control;
    timeunit 1ns;
    timeprecision 100ps;
    import mac_irq_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic tx_begin_i = 1'b0, rx_coll_wrap_i = 1'b0, tx_end_i = 1'b0, tx_err_i = 1'b0;
    logic desc_last_tx_irq_i = 1'b0, tx_frame_valid_i = 1'b0;
    logic descriptor_add_checksum_i = 1'b0, disable_tx_checksum_i = 1'b0;
    logic [15:0] tx_frame_len_i = 16'h0000;
    logic [31:0] rdata_o;
    logic tx_decision_valid_o, tx_pad_o, tx_append_checksum_o;
    logic irq_output_pin_o, stop_pulse_o, soft_reset_pulse_o;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] qe[$];
    logic [1:0] qd[$];
    logic rd_d = 1'b0;

    always #2.5 clock_i = ~clock_i;

    mac_interrupt_flag_control uut (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .tx_begin_i, .rx_coll_wrap_i, .tx_end_i, .tx_err_i, .desc_last_tx_irq_i,
        .tx_frame_valid_i, .tx_frame_len_i, .descriptor_add_checksum_i,
        .disable_tx_checksum_i, .tx_decision_valid_o, .tx_pad_o, .tx_append_checksum_o,
        .irq_output_pin_o, .stop_pulse_o, .soft_reset_pulse_o);

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    // Expected word is queued; the monitor compares it when the data appear
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        qe.push_back(e);
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask : rd

    task automatic ev(int k, logic er = 1'b0, logic lt = 1'b0);
        @(posedge clock_i);
        tx_err_i <= er;
        desc_last_tx_irq_i <= lt;
        case (k)
            0: tx_begin_i <= 1'b1;
            1: rx_coll_wrap_i <= 1'b1;
            default: tx_end_i <= 1'b1;
        endcase
        @(posedge clock_i);
        {tx_begin_i, rx_coll_wrap_i, tx_end_i} <= 3'h0;
    endtask : ev

    task automatic ck_irq(logic e);
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        chk("irq", {31'h0, e}, {31'h0, irq_output_pin_o});
    endtask : ck_irq

    always @(posedge clock_i) rd_d <= rd_i;
    always @(negedge clock_i) begin
        if (rd_d) chk("rdata", qe.pop_front(), rdata_o);
        if (tx_decision_valid_o === 1'b1) begin
            chk("decision", {30'h0, qd.pop_front()},
                {30'h0, tx_pad_o, tx_append_checksum_o});
        end
    end

    initial begin
        repeat (3000) @(posedge clock_i);
        n_fail++;
        stop_test();
    end

    initial begin
        logic e;
        logic ad;
        logic ds;
        logic [15:0] len;
        void'($urandom(32'h751f));
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(OFF_FEAT, 32'h14);
        rd(OFF_EXTC, 32'h0);
        rd(OFF_CTRL, 32'h0);
        rd(8'h04, 32'h0);
        $display("test reset done");
        wr(OFF_CTRL, 32'h1);
        wr(OFF_FEAT, 32'h80);
        ck_irq(1'b1);
        rd(OFF_FEAT, 32'hc0);
        wr(OFF_FEAT, 32'hc0);
        ck_irq(1'b0);
        rd(OFF_FEAT, 32'h0);
        $display("test user irq done");
        ev(1);
        ck_irq(1'b1);
        wr(OFF_FEAT, 32'h0);
        rd(OFF_FEAT, 32'h20);
        wr(OFF_FEAT, 32'h20);
        rd(OFF_FEAT, 32'h0);
        ck_irq(1'b0);
        $display("test overflow done");
        wr(OFF_FEAT, 32'h14);
        ev(0);
        ev(1);
        ck_irq(1'b0);
        rd(OFF_FEAT, 32'h3c);
        rd(OFF_CTRL, 32'h1);
        wr(OFF_CTRL, 32'h3);
        rd(OFF_FEAT, 32'h14);
        wr(OFF_FEAT, 32'h0);
        ev(0);
        ck_irq(1'b1);
        rd(OFF_CTRL, 32'h11);
        wr(OFF_CTRL, 32'h0);
        ck_irq(1'b0);
        wr(OFF_FEAT, 32'h08);
        $display("test masks done");
        wr(OFF_CTRL, 32'h1);
        for (int i = 0; i < 16; i++) begin
            wr(OFF_EXTC, {16'h0, i[3], i[2], 14'h0});
            ev(2, i[1], i[0]);
            e = i[2] ? (i[0] | i[1]) : (!i[3] | i[1]);
            rd(OFF_CTRL, {27'h0, e, e, 3'h1});
            wr(OFF_CTRL, 32'h9);
        end
        $display("test tx irq done");
        wr(OFF_FEAT, 32'h880);
        wr(OFF_EXTC, 32'hc000);
        wr(OFF_CTRL, 32'h4);
        rd(OFF_FEAT, 32'h14);
        rd(OFF_EXTC, 32'h0);
        rd(OFF_CTRL, 32'h0);
        $display("test soft reset done");
        for (int a = 0; a < 2; a++) begin
            wr(OFF_FEAT, {20'h0, a[0], 11'h0});
            for (int k = 0; k < 12; k++) begin
                len = k < 2 ? 16'h003f + 16'(k) : 16'($urandom_range(32, 96));
                ad = 1'($urandom);
                ds = 1'($urandom);
                @(posedge clock_i);
                tx_frame_valid_i <= 1'b1;
                tx_frame_len_i <= len;
                descriptor_add_checksum_i <= ad;
                disable_tx_checksum_i <= ds;
                e = a[0] && len < MIN_FRAME;
                qd.push_back({e, e | ad | !ds});
            end
            @(posedge clock_i);
            tx_frame_valid_i <= 1'b0;
        end
        repeat (4) @(posedge clock_i);
        $display("test pad done");
        stop_test();
    end
endmodule : tb_mac_interrupt_flag_control
